// *** dv/aux_converter_model.sv ***
// behavioural converter answering start pulses
`timescale 1ns/1ps
module aux_converter_model #(
	parameter int HOLD = 20
) (
	input wire logic mclk,
	input wire logic convStart,
	input wire logic [2:0] convChannel,
	input wire logic slow,
	output logic convDone,
	output logic [11:0] convResult
);
	logic [11:0] last;
	// value tied to channel; inverse when idle so a stale read shows
	initial begin
		convDone = 1'b0;
		convResult = 12'hfff;
		forever begin
			@(posedge mclk);
			if (convStart === 1'b1) begin
				last = 12'h035 * ({9'h000, convChannel} + 12'h001);
				#1 convResult = last;
				if (convChannel >= 3'h5) begin
					repeat (HOLD) @(posedge mclk);
				end else begin
					repeat (slow ? 30 : 10) @(posedge mclk);
					#1 convDone = 1'b1;
					@(posedge mclk);
				end
				#1 convDone = 1'b0;
				convResult = ~last;
			end
		end
	end
endmodule // aux_converter_model

// *** dv/burst_aux_ctrl_properties.sv ***
// port checker for burst and converter control
`timescale 1ns/1ps
module burst_aux_ctrl_properties #(
	parameter int OFFSET_MEAS_CYCLES = burst_aux_pkg::OFFSET_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic regRead,
	input wire logic [11:0] readData,
	input wire logic readValid,
	input wire logic rampStrobe,
	input wire logic [3:0] rampEntry,
	input wire logic convStart,
	input wire logic [2:0] convChannel,
	input wire logic bbRxValid,
	input wire logic bbRxValidOut
);
	int gap;
	logic lastOff;
	// cycles since the last start, and whether it was an offset one
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			gap <= 0;
			lastOff <= 1'b0;
		end else if (convStart) begin
			gap <= 1;
			lastOff <= convChannel >= 3'h5;
		end else if (gap < 100000) begin
			gap <= gap + 1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// ==========
	// register reads
	chk_read_answer: assert property (regRead |=> readValid)
		else $error("read not answered");
	chk_read_hold: assert property (!readValid |-> $stable(readData))
		else $error("read data moved");
	// ==========
	// ramp and converter sequencing, receive sample pass-through
	chk_ramp_spacing: assert property (rampStrobe && rampEntry != 4'hf |-> ##24 rampStrobe)
		else $error("ramp entry late");
	chk_ramp_gap: assert property (rampStrobe |=> !rampStrobe [*8])
		else $error("ramp entry early");
	chk_start_gap: assert property (convStart |=> !convStart [*8])
		else $error("overlapping starts");
	chk_offset_length: assert property (convStart && lastOff |-> gap >= OFFSET_MEAS_CYCLES)
		else $error("offset window short");
	chk_channel_hold: assert property (!convStart |-> $stable(convChannel))
		else $error("channel moved");
	chk_bb_pass: assert property (bbRxValid |=> bbRxValidOut)
		else $error("sample lost");
endmodule // burst_aux_ctrl_properties

bind burst_aux_ctrl burst_aux_ctrl_properties #(.OFFSET_MEAS_CYCLES(OFFSET_MEAS_CYCLES)) u_props (
	.mclk(mclk), .rstn(rstn), .regRead(regRead), .readData(readData), .readValid(readValid),
	.rampStrobe(rampStrobe), .rampEntry(rampEntry), .convStart(convStart),
	.convChannel(convChannel), .bbRxValid(bbRxValid), .bbRxValidOut(bbRxValidOut)
);

// *** dv/testbench.sv ***
// self-checking bench for burst timing and converter control
`timescale 1ns/1ps
module testbench;
	localparam int MEAS = 20;
	logic mclk, rstn, transmitOnPin, regWrite, regRead, readValid, rampStrobe, burstStrobeOut;
	logic convStart, convDone, bbRxValid, bbRxValidOut, slow, prevB;
	logic [3:0] regAddr, rampEntry, convRequest;
	logic [11:0] regData, readData, convResult, bbRxI, bbRxQ, bbRxIOut, bbRxQOut, v, e;
	logic [1:0] rampPhase;
	logic [2:0] convChannel;
	logic [11:0] dly [2][5];
	logic [6:0] cd [2];
	logic [8:0] off [3];
	logic [2:0] seen [$];
	logic [2:0] want [$];
	logic [7:0] places [12] = '{8'h40, 8'h41, 8'h44, 8'h45, 8'h46, 8'h47, 8'h50, 8'h60,
		8'h70, 8'h80, 8'h90, 8'hb0};
	int n_mismatch, comparisons, cyc, nDone, t0, k, i;
	int nRamp [3];
	int tF [2], tR [2], tC [2];
	int tRamp [2][3];

	burst_aux_ctrl #(.OFFSET_MEAS_CYCLES(MEAS)) u_burst_aux_ctrl (
		.mclk(mclk), .rstn(rstn), .transmitOnPin(transmitOnPin), .regWrite(regWrite),
		.regAddr(regAddr), .regData(regData), .regRead(regRead), .readData(readData),
		.readValid(readValid), .rampStrobe(rampStrobe), .rampEntry(rampEntry),
		.rampPhase(rampPhase), .burstStrobeOut(burstStrobeOut), .convRequest(convRequest),
		.convStart(convStart), .convChannel(convChannel), .convDone(convDone),
		.convResult(convResult), .bbRxValid(bbRxValid), .bbRxI(bbRxI), .bbRxQ(bbRxQ),
		.bbRxValidOut(bbRxValidOut), .bbRxIOut(bbRxIOut), .bbRxQOut(bbRxQOut)
	);
	aux_converter_model #(.HOLD(MEAS)) u_aux_converter_model (
		.mclk(mclk), .convStart(convStart), .convChannel(convChannel), .slow(slow),
		.convDone(convDone), .convResult(convResult)
	);

	// ==========
	// expectations
	function automatic logic [11:0] conv(logic [2:0] c);
		return 12'h035 * ({9'h000, c} + 12'h001);
	endfunction
	function automatic logic [11:0] sx(logic [8:0] o);
		return {{3{o[8]}}, o};
	endfunction
	task automatic check(string what, logic [11:0] exp, logic [11:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========
	// register access; one idle cycle between strobes
	task automatic wr(logic [3:0] a, logic [11:0] d);
		regAddr = a;
		regData = d;
		regWrite = 1'b1;
		@(posedge mclk);
		#1 regWrite = 1'b0;
		regData = ~d;
		@(posedge mclk);
		#1;
	endtask
	task automatic rd(logic [7:0] p, output logic [11:0] q);
		wr(4'h0, {4'h0, p});
		regRead = 1'b1;
		@(posedge mclk);
		#1 regRead = 1'b0;
		check("read valid", 12'h001, {11'h000, readValid});
		q = readData;
		@(posedge mclk);
		#1;
	endtask
	// program one burst, raise transmit-on and count ramp entries
	task automatic run_burst();
		for (i = 0; i < 5; i++) begin
			wr(4'h3, {4'(2 * i), dly[k][i][7:0]});
			wr(4'h3, {4'(2 * i + 1), 4'h0, dly[k][i][11:8]});
		end
		wr(4'h3, {4'ha, 7'h00, k[0]});
		wr(4'h4, {5'h00, cd[k]});
		nRamp = '{0, 0, 0};
		t0 = cyc;
		transmitOnPin = 1'b1;
		repeat (1900) @(posedge mclk);
		#1 transmitOnPin = 1'b0;
		check("up entries", 12'h010, 12'(nRamp[0]));
		check("mid entries", 12'(k * 16), 12'(nRamp[1]));
		check("down entries", 12'h010, 12'(nRamp[2]));
	endtask

	// clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// event times, start order and hang limit
	always @(posedge mclk) begin
		cyc++;
		if (prevB === 1'b1 && burstStrobeOut === 1'b0) tF[k] = cyc - t0;
		if (prevB === 1'b0 && burstStrobeOut === 1'b1) tR[k] = cyc - t0;
		prevB = burstStrobeOut;
		if (rampStrobe === 1'b1) begin
			check("ramp entry", {8'h00, 4'(nRamp[rampPhase])}, {8'h00, rampEntry});
			nRamp[rampPhase] = nRamp[rampPhase] + 1;
			if (rampEntry === 4'h0) tRamp[k][rampPhase] = cyc - t0;
		end
		if (convStart === 1'b1) seen.push_back(convChannel);
		if (convStart === 1'b1 && convChannel === 3'h0) tC[k] = cyc - t0;
		if (convDone === 1'b1) nDone++;
		if (cyc == 30000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	// main sequence
	initial begin
		void'($urandom(32'hc6e7));
		{rstn, transmitOnPin, regWrite, regRead, bbRxValid, slow} = 6'h00;
		{regAddr, convRequest, regData, bbRxI, bbRxQ} = 44'h0;
		prevB = 1'b1;
		k = 0;
		repeat (8) @(posedge mclk);
		#1 rstn = 1'b1;
		// reset values; trigger and unmapped places read zero
		for (int j = 0; j < 12; j++) begin
			rd(places[j], v);
			check("reset value", 12'h000, v);
		end
		cd[0] = 7'($urandom);
		wr(4'h4, {5'h00, cd[0]});
		rd(8'h40, v);
		check("conversion delay", {5'h00, cd[0]}, v);
		for (i = 0; i < 3; i++) begin
			off[i] = (i == 1) ? 9'h100 : 9'($urandom);
			wr(4'h4, {3'(4 + i), off[i]});
			rd(8'(8'h44 + i), v);
			check("offset", {3'h0, off[i]}, {3'h0, v[8:0]});
		end
		// receive samples lose the signed offsets
		for (i = 0; i < 6; i++) begin
			bbRxValid = 1'b1;
			bbRxI = 12'($urandom);
			bbRxQ = (i == 0) ? 12'h000 : 12'($urandom);
			@(posedge mclk);
			#1 bbRxValid = 1'b0;
			check("rx valid", 12'h001, {11'h000, bbRxValidOut});
			check("i sample", bbRxI - sx(off[1]), bbRxIOut);
			check("q sample", bbRxQ - sx(off[2]), bbRxQOut);
			@(posedge mclk);
			#1;
			check("rx idle", 12'h000, {11'h000, bbRxValidOut});
		end
		// all three offset measurements at once
		seen.delete();
		wr(4'h4, {3'h7, 9'h007});
		rd(8'h41, v);
		check("pending flags", 12'h0e0, v);
		repeat (4 * MEAS) @(posedge mclk);
		#1;
		want = '{3'h7, 3'h6, 3'h5};
		for (i = 0; i < 3; i++) begin
			check("offset order", {9'h000, want[i]}, {9'h000, seen[i]});
			e = conv(3'(5 + i));
			off[i] = e[8:0];
			rd(8'(8'h44 + i), v);
			check("measured offset", {3'h0, off[i]}, {3'h0, v[8:0]});
		end
		// normal conversions, prompt then slow converter
		for (k = 0; k < 2; k++) begin
			slow = k[0];
			seen.delete();
			nDone = 0;
			convRequest = (k == 0) ? 4'hf : 4'(1 + $urandom % 15);
			want.delete();
			for (i = 3; i >= 0; i--) if (convRequest[i]) want.push_back(3'(i + 1));
			@(posedge mclk);
			#1 convRequest = 4'h0;
			for (i = 0; i < 400 && nDone < want.size(); i++) @(posedge mclk);
			@(posedge mclk);
			#1;
			check("starts", 12'(want.size()), 12'(seen.size()));
			for (i = 0; i < want.size(); i++) begin
				check("start order", {9'h000, want[i]}, {9'h000, seen[i]});
				rd({4'h5 + {1'b0, want[i]}, 4'h0}, v);
				check("result", conv(want[i]) - sx(off[0]), v);
			end
			rd(8'h41, v);
			check("flags idle", 12'h000, v);
		end
		// two bursts: single then multislot
		for (k = 0; k < 2; k++) begin
			dly[k][0] = (k == 0) ? 12'h000 : 12'($urandom % 16);
			dly[k][1] = dly[k][0] + 12'(33 + $urandom % 16);
			dly[k][2] = dly[k][1] + 12'(33 + $urandom % 16);
			dly[k][3] = 12'($urandom % 40);
			dly[k][4] = dly[k][3] + 12'(1 + $urandom % 40);
			cd[k] = 7'(1 + $urandom % 8);
			run_burst();
			rd(8'h50, v);
			check("in-burst result", conv(3'h0) - sx(off[0]), v);
			// burst registers read back what was programmed
			rd(8'h3a, v);
			check("burst mode", {11'h000, k[0]}, v);
			rd(8'h34, v);
			check("ramp-down lo", {4'h0, dly[k][2][7:0]}, v);
			rd(8'h35, v);
			check("ramp-down hi", {8'h00, dly[k][2][11:8]}, v);
		end
		check("up start", 12'(12 * (dly[1][0] - dly[0][0])), 12'(tRamp[1][0] - tRamp[0][0]));
		check("mid start", 12'(12 * (dly[1][1] - dly[1][0])), 12'(tRamp[1][1] - tRamp[1][0]));
		check("down start", 12'(12 * (dly[1][2] - dly[0][2])), 12'(tRamp[1][2] - tRamp[0][2]));
		check("strobe fall", 12'(12 * (dly[1][3] - dly[0][3])), 12'(tF[1] - tF[0]));
		check("strobe rise", 12'(12 * (dly[1][4] - dly[1][3])), 12'(tR[1] - tF[1]));
		check("burst conversion", 12'(48 * (cd[1] - cd[0])), 12'(tC[1] - tC[0]));
		report_and_stop();
	end
endmodule // testbench

// *** logic/burst_aux_ctrl.sv ***
// burst timing and auxiliary converter control register block
// Function
// - ramp-up starts after programmed quarterbit delay
// - sixteen ramp entries, one per 24 clocks
// - mid ramp only in multislot mode
// - ramp-down starts after its quarterbit delay
// - burst strobe falls after first delay
// - strobe rises after second, larger delay
// - converter register split by 3-bit subaddress
// - in-burst conversion after 48-clock unit delay
// - read-only flags show pending measurements
// - flag bits Q,I,aux,ch4,ch3,ch2,1B,1A
// - signed offsets subtracted from samples, results
// - offset registers read/write, reset to zero
// - trigger write starts selected offset measurements
// - offset measurements run one after another
// - each offset measurement takes about 100 us
// - channel 1 keeps in and out results
// - channels 2-4 results in bits 11:0
// - delays built from a low byte and a high nibble
`timescale 1ns/1ps
module burst_aux_ctrl #(
	parameter int OFFSET_MEAS_CYCLES = burst_aux_pkg::OFFSET_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic transmitOnPin,
	input wire logic regWrite,
	input wire logic [3:0] regAddr,
	input wire logic [11:0] regData,
	input wire logic regRead,
	output logic [11:0] readData,
	output logic readValid,
	output logic rampStrobe,
	output logic [3:0] rampEntry,
	output logic [1:0] rampPhase,
	output logic burstStrobeOut,
	input wire logic [3:0] convRequest,
	output logic convStart,
	output logic [2:0] convChannel,
	input wire logic convDone,
	input wire logic [11:0] convResult,
	input wire logic bbRxValid,
	input wire logic [11:0] bbRxI,
	input wire logic [11:0] bbRxQ,
	output logic bbRxValidOut,
	output logic [11:0] bbRxIOut,
	output logic [11:0] bbRxQOut
);
	localparam int MW = $clog2(OFFSET_MEAS_CYCLES + 1);

	// ==========================================
	// registers
	logic [11:0] delays [burst_aux_pkg::NUM_DELAYS];
	logic multislot;
	logic [6:0] convDelay;
	logic [8:0] offsets [3];
	logic [11:0] results [burst_aux_pkg::NUM_RESULTS];
	logic [7:0] pending;
	logic [3:0] readAddr;
	logic [3:0] readSub;
	logic burstWrite;
	logic convWrite;
	logic [3:0] burstSub;
	logic [2:0] convSub;

	// write decode
	assign burstWrite = regWrite && regAddr == burst_aux_pkg::ADDR_BURST;
	assign convWrite = regWrite && regAddr == burst_aux_pkg::ADDR_CONV_CTRL;
	assign burstSub = regData[burst_aux_pkg::SUB_BURST_MSB:burst_aux_pkg::SUB_BURST_LSB];
	assign convSub = regData[burst_aux_pkg::SUB_BURST_MSB:burst_aux_pkg::SUB_CONV_LSB];

	for (genvar d = 0; d < burst_aux_pkg::NUM_DELAYS; d++) begin : gDelay
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				delays[d] <= burst_aux_pkg::DELAY_RESET;
			end else if (burstWrite && burstSub[3:1] == 3'(d)) begin
				if (burstSub[0]) begin
					delays[d][11:8] <= regData[3:0];
				end else begin
					delays[d][7:0] <= regData[7:0];
				end
			end
		end
	end

	// single or double burst mode
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			multislot <= 1'b0;
		end else if (burstWrite && burstSub == burst_aux_pkg::SUB_MODE) begin
			multislot <= regData[0];
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			convDelay <= burst_aux_pkg::CONV_DELAY_RESET;
		end else if (convWrite && convSub == burst_aux_pkg::SUB_CONV_DELAY) begin
			convDelay <= regData[6:0];
		end
	end

	// ==========================================
	// transmit-on synchroniser and quarterbit counter
	logic txSync1;
	logic txSync2;
	logic txPrev;
	logic txRise;
	logic running;
	logic [3:0] qbDiv;
	logic [11:0] qbCount;
	logic qbEdge;

	// pin crosses two flops before the edge detector
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			txSync1 <= 1'b0;
			txSync2 <= 1'b0;
			txPrev <= 1'b0;
		end else begin
			txSync1 <= transmitOnPin;
			txSync2 <= txSync1;
			txPrev <= txSync2;
		end
	end
	assign txRise = txSync2 && !txPrev;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			running <= 1'b0;
			qbDiv <= 4'h0;
			qbCount <= 12'h000;
		end else if (txRise) begin
			running <= 1'b1;
			qbDiv <= 4'h0;
			qbCount <= 12'h000;
		end else if (running) begin
			if (qbDiv == 4'(burst_aux_pkg::QB_CYCLES - 1)) begin
				qbDiv <= 4'h0;
				// stop the counter at 0xfff so a late event cannot fire twice
				if (qbCount == 12'hfff) begin
					running <= 1'b0;
				end else begin
					qbCount <= qbCount + 12'h001;
				end
			end else begin
				qbDiv <= qbDiv + 4'h1;
			end
		end
	end
	assign qbEdge = running && qbDiv == 4'h0;

	// event strobes, one cycle at the start of the matching quarterbit
	logic [burst_aux_pkg::NUM_DELAYS-1:0] evt;
	logic convEvt;
	for (genvar e = 0; e < burst_aux_pkg::NUM_DELAYS; e++) begin : gEvt
		assign evt[e] = qbEdge && qbCount == delays[e];
	end
	assign convEvt = qbEdge &&
		qbCount == 12'({5'h00, convDelay} * burst_aux_pkg::CONV_UNIT_QB);

	// ==========================================
	// ramp sequencer
	logic [4:0] stepDiv;
	logic rampActive;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rampActive <= 1'b0;
			rampPhase <= burst_aux_pkg::RAMP_UP;
			rampEntry <= 4'h0;
			stepDiv <= 5'h00;
		end else if (evt[burst_aux_pkg::DLY_RU]) begin
			rampActive <= 1'b1;
			rampPhase <= burst_aux_pkg::RAMP_UP;
			rampEntry <= 4'h0;
			stepDiv <= 5'h00;
		end else if (evt[burst_aux_pkg::DLY_RM] && multislot) begin
			rampActive <= 1'b1;
			rampPhase <= burst_aux_pkg::RAMP_MID;
			rampEntry <= 4'h0;
			stepDiv <= 5'h00;
		end else if (evt[burst_aux_pkg::DLY_RD]) begin
			rampActive <= 1'b1;
			rampPhase <= burst_aux_pkg::RAMP_DOWN;
			rampEntry <= 4'h0;
			stepDiv <= 5'h00;
		end else if (rampActive) begin
			if (stepDiv == 5'(burst_aux_pkg::RAMP_STEP_CYCLES - 1)) begin
				stepDiv <= 5'h00;
				rampEntry <= rampEntry + 4'h1;
			end else begin
				stepDiv <= stepDiv + 5'h01;
			end
			if (stepDiv == 5'h00 &&
				rampEntry == 4'(burst_aux_pkg::RAMP_ENTRIES - 1)) begin
				rampActive <= 1'b0;
			end
		end
	end
	// strobe marks each of the sixteen entries
	assign rampStrobe = rampActive && stepDiv == 5'h00;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			burstStrobeOut <= burst_aux_pkg::STROBE_IDLE;
		end else if (evt[burst_aux_pkg::DLY_RISE]) begin
			burstStrobeOut <= 1'b1;
		end else if (evt[burst_aux_pkg::DLY_FALL]) begin
			burstStrobeOut <= 1'b0;
		end
	end

	// ==========================================
	// converter sequencer
	burst_aux_pkg::seq_state_t seqState;
	logic [MW-1:0] measCount;
	logic [7:0] setPend;
	logic [7:0] clrPend;
	logic [2:0] nextChannel;
	logic seqFinish;

	// highest pending code wins, so offsets go ahead of channels
	always_comb begin
		nextChannel = 3'h0;
		for (int i = 0; i < burst_aux_pkg::NUM_FLAGS; i++) begin
			if (pending[i]) begin
				nextChannel = 3'(i);
			end
		end
	end

	// trigger bits Q,I,aux map onto flags 7:5
	assign setPend = {convWrite && convSub == burst_aux_pkg::SUB_TRIGGER ? regData[2:0] : 3'h0,
		convRequest, convEvt};

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			seqState <= burst_aux_pkg::SEQ_IDLE;
			convStart <= 1'b0;
			convChannel <= 3'h0;
			measCount <= '0;
		end else begin
			convStart <= 1'b0;
			unique case (seqState)
				burst_aux_pkg::SEQ_IDLE: begin
					if (|pending) begin
						convStart <= 1'b1;
						convChannel <= nextChannel;
						measCount <= '0;
						if (nextChannel >= 3'(burst_aux_pkg::FLAG_FIRST_OFF)) begin
							seqState <= burst_aux_pkg::SEQ_OFFS;
						end else begin
							seqState <= burst_aux_pkg::SEQ_CONV;
						end
					end
				end
				burst_aux_pkg::SEQ_CONV: begin
					if (convDone) begin
						seqState <= burst_aux_pkg::SEQ_IDLE;
					end
				end
				burst_aux_pkg::SEQ_OFFS: begin
					if (measCount == MW'(OFFSET_MEAS_CYCLES - 1)) begin
						seqState <= burst_aux_pkg::SEQ_IDLE;
					end else begin
						measCount <= measCount + 1'b1;
					end
				end
				default: begin
					seqState <= burst_aux_pkg::SEQ_IDLE;
				end
			endcase
		end
	end
	assign seqFinish = (seqState == burst_aux_pkg::SEQ_CONV && convDone) ||
		(seqState == burst_aux_pkg::SEQ_OFFS && measCount == MW'(OFFSET_MEAS_CYCLES - 1));

	// clear together with the result store
	always_comb begin
		clrPend = 8'h00;
		clrPend[convChannel] = seqFinish;
	end

	// pending flags, a new request beats the clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pending <= 8'h00;
		end else begin
			pending <= (pending & ~clrPend) | setPend;
		end
	end

	// ==========================================
	// offsets and results
	logic [11:0] auxOffWide;
	assign auxOffWide = {{3{offsets[0][8]}}, offsets[0]};

	// host writes, measured value wins on a tie
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int k = 0; k < 3; k++) begin
				offsets[k] <= burst_aux_pkg::OFFSET_RESET;
			end
		end else begin
			for (int k = 0; k < 3; k++) begin
				if (seqFinish && seqState == burst_aux_pkg::SEQ_OFFS &&
					convChannel == 3'(burst_aux_pkg::FLAG_FIRST_OFF + k)) begin
					offsets[k] <= convResult[8:0];
				end else if (convWrite && convSub == burst_aux_pkg::SUB_AUX_OFF + 3'(k)) begin
					offsets[k] <= regData[8:0];
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int r = 0; r < burst_aux_pkg::NUM_RESULTS; r++) begin
				results[r] <= burst_aux_pkg::RESULT_RESET;
			end
		end else if (seqFinish && seqState == burst_aux_pkg::SEQ_CONV) begin
			results[convChannel] <= convResult - auxOffWide;
		end
	end

	// baseband receive correction, wraps on overflow
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bbRxValidOut <= 1'b0;
			bbRxIOut <= 12'h000;
			bbRxQOut <= 12'h000;
		end else begin
			bbRxValidOut <= bbRxValid;
			if (bbRxValid) begin
				bbRxIOut <= bbRxI - {{3{offsets[1][8]}}, offsets[1]};
				bbRxQOut <= bbRxQ - {{3{offsets[2][8]}}, offsets[2]};
			end
		end
	end

	// ==========================================
	// read path
	logic [11:0] readMux;
	logic [2:0] rdIdx;
	assign rdIdx = readSub[3:1];

	// address latched from the read request
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			readAddr <= 4'h0;
			readSub <= 4'h0;
		end else if (regWrite && regAddr == burst_aux_pkg::ADDR_READ_REQ) begin
			readAddr <= regData[7:4];
			readSub <= regData[3:0];
		end
	end

	// flag order; write-only and unmapped read zero
	always_comb begin
		readMux = 12'h000;
		unique case (readAddr)
			burst_aux_pkg::ADDR_BURST: begin
				if (readSub == burst_aux_pkg::SUB_MODE) begin
					readMux = {11'h000, multislot};
				end else if (rdIdx < 3'(burst_aux_pkg::NUM_DELAYS)) begin
					readMux = readSub[0] ? {8'h00, delays[rdIdx][11:8]} :
						{4'h0, delays[rdIdx][7:0]};
				end
			end
			burst_aux_pkg::ADDR_CONV_CTRL: begin
				unique case (readSub[2:0])
					burst_aux_pkg::SUB_CONV_DELAY: readMux = {5'h00, convDelay};
					burst_aux_pkg::SUB_FLAGS: readMux = {4'h0, pending};
					burst_aux_pkg::SUB_AUX_OFF: readMux = {3'h0, offsets[0]};
					burst_aux_pkg::SUB_I_OFF: readMux = {3'h0, offsets[1]};
					burst_aux_pkg::SUB_Q_OFF: readMux = {3'h0, offsets[2]};
					default: readMux = 12'h000;
				endcase
			end
			burst_aux_pkg::ADDR_CH1A: readMux = results[0];
			burst_aux_pkg::ADDR_CH1B: readMux = results[1];
			burst_aux_pkg::ADDR_CH2: readMux = results[2];
			burst_aux_pkg::ADDR_CH3: readMux = results[3];
			burst_aux_pkg::ADDR_CH4: readMux = results[4];
			default: readMux = 12'h000;
		endcase
	end

	// registered read answer
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			readData <= 12'h000;
			readValid <= 1'b0;
		end else begin
			readValid <= regRead;
			if (regRead) begin
				readData <= readMux;
			end
		end
	end
endmodule // burst_aux_ctrl

// *** logic/burst_aux_pkg.sv ***
// constants and types for burst timing and auxiliary converter control
package burst_aux_pkg;
	// ==========================================
	// register addresses
	localparam logic [3:0] ADDR_READ_REQ = 4'h0;
	localparam logic [3:0] ADDR_BURST = 4'h3;
	localparam logic [3:0] ADDR_CONV_CTRL = 4'h4;
	localparam logic [3:0] ADDR_CH1A = 4'h5;
	localparam logic [3:0] ADDR_CH1B = 4'h6;
	localparam logic [3:0] ADDR_CH2 = 4'h7;
	localparam logic [3:0] ADDR_CH3 = 4'h8;
	localparam logic [3:0] ADDR_CH4 = 4'h9;
	// ==========================================
	// burst control subaddresses, bits 11:8 of a write
	localparam logic [3:0] SUB_MODE = 4'ha;
	localparam int SUB_BURST_MSB = 11;
	localparam int SUB_BURST_LSB = 8;
	localparam int NUM_DELAYS = 5;
	localparam int DLY_RU = 0;
	localparam int DLY_RM = 1;
	localparam int DLY_RD = 2;
	localparam int DLY_FALL = 3;
	localparam int DLY_RISE = 4;
	// ==========================================
	// converter control subaddresses, bits 11:9 of a write
	localparam logic [2:0] SUB_CONV_DELAY = 3'h0;
	localparam logic [2:0] SUB_FLAGS = 3'h1;
	localparam logic [2:0] SUB_AUX_OFF = 3'h4;
	localparam logic [2:0] SUB_I_OFF = 3'h5;
	localparam logic [2:0] SUB_Q_OFF = 3'h6;
	localparam logic [2:0] SUB_TRIGGER = 3'h7;
	localparam int SUB_CONV_LSB = 9;
	// ==========================================
	// pending flag bits, also the converter channel codes
	localparam int FLAG_CH1A = 0;
	localparam int FLAG_FIRST_OFF = 5;
	localparam int NUM_FLAGS = 8;
	localparam int NUM_RESULTS = 5;
	// ==========================================
	// reset values
	localparam logic [11:0] DELAY_RESET = 12'h000;
	localparam logic [6:0] CONV_DELAY_RESET = 7'h00;
	localparam logic [8:0] OFFSET_RESET = 9'h000;
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam logic STROBE_IDLE = 1'b1;
	// ==========================================
	// timing
	localparam int QB_CYCLES = 12;
	localparam int RAMP_STEP_CYCLES = 24;
	localparam int RAMP_ENTRIES = 16;
	localparam int CONV_UNIT_CYCLES = 48;
	localparam int CONV_UNIT_QB = CONV_UNIT_CYCLES / QB_CYCLES;
	localparam int OFFSET_TIME_US = 100;
	localparam int MCLK_MHZ = 125;
	localparam int OFFSET_CYCLES = OFFSET_TIME_US * MCLK_MHZ;
	// ==========================================
	// types
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_CONV = 2'b01,
		SEQ_OFFS = 2'b11
	} seq_state_t;
	typedef enum logic [1:0] {
		RAMP_UP = 2'h0,
		RAMP_MID = 2'h1,
		RAMP_DOWN = 2'h2
	} ramp_phase_t;
endpackage
